/* rtl/ccc_pkg.sv */
/*
  Shared constants and carriers for the cache and configuration control block.
  Assumes a single system clock and a synchronous active-high reset.
*/
package ccc_pkg;

  // Coprocessor register numbers.
  localparam logic [3:0] CCC_REG_CTRL   = 4'h1;
  localparam logic [3:0] CCC_REG_TTB    = 4'h2;
  localparam logic [3:0] CCC_REG_DAC    = 4'h3;
  localparam logic [3:0] CCC_REG_RSV4   = 4'h4;
  localparam logic [3:0] CCC_REG_FSR    = 4'h5;
  localparam logic [3:0] CCC_REG_FAR    = 4'h6;
  localparam logic [3:0] CCC_REG_FLUSH  = 4'h7;
  localparam logic [3:0] CCC_REG_LASTOK = 4'h7;

  // Control register field positions.
  localparam int CCC_BIT_MMU   = 0;
  localparam int CCC_BIT_ALIGN = 1;
  localparam int CCC_BIT_CACHE = 2;
  localparam int CCC_BIT_WBUF  = 3;
  localparam int CCC_BIT_PROG  = 4;
  localparam int CCC_BIT_DATA  = 5;
  localparam int CCC_BIT_BIG   = 7;
  localparam int CCC_BIT_SYS   = 8;
  localparam int CCC_BIT_ROM   = 9;

  // Writable control bits and reset values.
  localparam logic [31:0] CCC_CTRL_MASK  = 32'h0000_03bf;
  localparam logic [31:0] CCC_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CCC_FSR_MASK   = 32'h0000_00ff;

  // Cache geometry: 512 lines, 4 ways, 128 sets, 4 words a line.
  localparam int CCC_WAYS   = 4;
  localparam int CCC_SETS   = 128;
  localparam int CCC_WORDS  = 4;
  localparam int CCC_TAG_W  = 21;
  localparam logic [1:0] CCC_LAST_WORD = 2'h3;

  // Processor request carrier.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        swap;
    logic        cacheable;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ccc_req_s;

  // Coprocessor transfer carrier.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        user;
    logic [3:0]  regno;
    logic [31:0] wdata;
  } ccc_cp_s;

  typedef enum logic [3:0] {
    CCC_IDLE  = 4'b0001,
    CCC_FILL  = 4'b0010,
    CCC_SINGL = 4'b0100,
    CCC_WRITE = 4'b1000
  } ccc_state_e;

endpackage

/* rtl/ccc_cache_config_control.sv */
/*
  Configuration register bank and unified 4-way virtual cache.
  Assumes the core holds its request stable until req_done, and memory
  answers each access with mem_ack in the system clock domain.
*/
// Functional notes
// RL1: Privileged access only; user access traps.
// RL2: Bit 1 enables alignment fault checking.
// RL3: Bit 2 turns unified cache on.
// RL4: Bit 3 turns write buffer on.
// RL5: Bits 4,5 select 32 or 26-bit spaces.
// RL6: Bit 7 selects big-endian ordering.
// RL7: Register 2 holds write-only table base.
// RL8: Register 3 holds write-only domain access.
// RL9: Register 4 access has no effect.
// RL10: Fault status read; bits 11:8 zero.
// RL11: Register 5 write flushes whole TLB.
// RL12: Register 6 read gives fault address.
// RL13: Register 6 write purges one TLB entry.
// RL14: Register 7 write invalidates all lines.
// RL15: Registers 8 to 15 trap undefined.
// RL16: 512 lines, 16 bytes, 4-way, virtual.
// RL17: Line loading needs translation unit enabled.
// RL18: Chip reset disables and flushes cache.
// RL19: Lookup always; control bits gate allocation.
// RL20: Cacheable miss fills 4 words, random way.
// RL21: Uncacheable miss is single access only.
// RL22: Swap reads memory, updates copy, locks.
// RL23: Write misses don't allocate; hits update.
`timescale 1ns/10ps
module ccc_cache_config_control
  import ccc_pkg::*;
(
  input  wire logic        sys_clk,        // System clock, 25 MHz.
  input  wire logic        reset,          // Synchronous reset, active high.
  input  wire ccc_cp_s     cp,             // Coprocessor register transfer.
  output logic             cp_undef,       // Undefined-instruction trap pulse.
  output logic [31:0]      cp_rdata,       // Read data, registered.
  input  wire ccc_req_s    req,            // Core memory request.
  input  wire logic        data_fault,     // Data fault pulse from translation.
  input  wire logic [7:0]  fault_info,     // Domain and status of that fault.
  output logic             req_done,       // Request complete pulse.
  output logic [31:0]      req_rdata,      // Read data to the core.
  output logic             mem_req,        // External access request.
  output logic             mem_wr,         // External access is a write.
  output logic [31:0]      mem_addr,       // External word address.
  output logic [31:0]      mem_wdata,      // External write data.
  output logic             mem_lock,       // Indivisible access flag.
  input  wire logic        mem_ack,        // External access acknowledge.
  input  wire logic [31:0] mem_rdata,      // External read data.
  output logic             mmu_on,         // Translation unit enable.
  output logic             align_check,    // Alignment fault checking.
  output logic             wbuf_on,        // Write buffer enable.
  output logic             prog32,         // 32-bit program space.
  output logic             data32,         // 32-bit data space.
  output logic             big_endian,     // Byte order.
  output logic             sys_bit,        // Permission system bit.
  output logic             rom_bit,        // Permission ROM bit.
  output logic [31:0]      table_base,     // Translation table base.
  output logic [31:0]      domain_access,  // Domain access fields.
  output logic             tlb_flush,      // Flush whole TLB pulse.
  output logic             tlb_purge,      // Purge one entry pulse.
  output logic [31:0]      tlb_purge_addr  // Address to purge.
);

  // Register storage.
  logic [31:0] ctrl;
  logic [31:0] fsr;
  logic [31:0] far_q;

  // Cache arrays; the tags and data are indexed by the set.
  logic [CCC_TAG_W-1:0] tag_mem [CCC_WAYS][CCC_SETS];
  logic [31:0]          dat_mem [CCC_WAYS][CCC_SETS][CCC_WORDS];
  logic [CCC_SETS-1:0]  vld     [CCC_WAYS];

  ccc_state_e  state;
  logic [1:0]  fill_cnt;
  logic [1:0]  fill_way;
  logic [1:0]  rnd;
  logic        hit;
  logic [1:0]  hit_way;
  logic        cp_ok;
  logic        flush_all;
  logic        swap_wr;

  // Address fields of a virtual address.
  function automatic logic [6:0] set_of(input logic [31:0] a);
    return a[10:4];
  endfunction

  function automatic logic [CCC_TAG_W-1:0] tag_of(input logic [31:0] a);
    return a[31:11];
  endfunction

  // A transfer is legal only from a privileged mode to registers 0..7.
  assign cp_ok     = cp.valid && !cp.user && (cp.regno <= CCC_REG_LASTOK); // see RL1 see RL15
  assign flush_all = cp_ok && cp.write && (cp.regno == CCC_REG_FLUSH);     // see RL14

  // Trap pulse for user mode or out-of-range registers.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cp_undef <= 1'b0;
    end else begin
      cp_undef <= cp.valid && !cp_ok; // see RL1 see RL15
    end
  end

  // Configuration writes. Register 4 is decoded and dropped on purpose.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl          <= CCC_CTRL_RESET; // see RL18
      table_base    <= 32'h0000_0000;
      domain_access <= 32'h0000_0000;
    end else if (cp_ok && cp.write) begin
      if (cp.regno == CCC_REG_CTRL) begin
        ctrl <= cp.wdata & CCC_CTRL_MASK; // see RL17
      end
      if (cp.regno == CCC_REG_TTB) begin
        table_base <= cp.wdata; // see RL7
      end
      if (cp.regno == CCC_REG_DAC) begin
        domain_access <= cp.wdata; // see RL8
      end
    end
  end

  // Control bits steer the rest of the chip directly.
  assign mmu_on      = ctrl[CCC_BIT_MMU];
  assign align_check = ctrl[CCC_BIT_ALIGN]; // see RL2
  assign wbuf_on     = ctrl[CCC_BIT_WBUF];  // see RL4
  assign prog32      = ctrl[CCC_BIT_PROG];  // see RL5
  assign data32      = ctrl[CCC_BIT_DATA];  // see RL5
  assign big_endian  = ctrl[CCC_BIT_BIG];   // see RL6
  assign sys_bit     = ctrl[CCC_BIT_SYS];
  assign rom_bit     = ctrl[CCC_BIT_ROM];

  // TLB maintenance pulses; written data for flush is ignored.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tlb_flush      <= 1'b0;
      tlb_purge      <= 1'b0;
      tlb_purge_addr <= 32'h0000_0000;
    end else begin
      tlb_flush <= cp_ok && cp.write && (cp.regno == CCC_REG_FSR); // see RL11
      tlb_purge <= cp_ok && cp.write && (cp.regno == CCC_REG_FAR); // see RL13
      if (cp_ok && cp.write && (cp.regno == CCC_REG_FAR)) begin
        tlb_purge_addr <= cp.wdata; // see RL13
      end
    end
  end

  // Fault capture: only data faults reach this port, so prefetch faults never land here.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fsr   <= 32'h0000_0000;
      far_q <= 32'h0000_0000;
    end else if (data_fault) begin
      fsr   <= {24'h00_0000, fault_info} & CCC_FSR_MASK; // see RL10
      far_q <= req.addr;                                 // see RL12
    end
  end

  // Read data. Write-only and reserved registers read as zero.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cp_rdata <= 32'h0000_0000;
    end else if (cp_ok && !cp.write) begin
      unique case (cp.regno)
        CCC_REG_CTRL: cp_rdata <= ctrl;
        CCC_REG_FSR:  cp_rdata <= fsr;   // see RL10
        CCC_REG_FAR:  cp_rdata <= far_q; // see RL12
        default:      cp_rdata <= 32'h0000_0000; // see RL9
      endcase
    end
  end

  // Lookup across all ways, whatever the enable bits say.
  always_comb begin
    hit     = 1'b0;
    hit_way = 2'h0;
    for (int w = 0; w < CCC_WAYS; w++) begin
      if (vld[w][set_of(req.addr)] && tag_mem[w][set_of(req.addr)] == tag_of(req.addr)) begin
        hit     = 1'b1; // see RL16 see RL19
        hit_way = w[1:0];
      end
    end
  end

  // Free-running counter serves as the random way choice.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rnd <= 2'h0;
    end else begin
      rnd <= rnd + 2'h1; // see RL20
    end
  end

  // Access sequencer.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state    <= CCC_IDLE;
      fill_cnt <= 2'h0;
      fill_way <= 2'h0;
      swap_wr  <= 1'b0;
      req_done <= 1'b0;
      req_rdata <= 32'h0000_0000;
    end else begin
      req_done <= 1'b0;
      unique case (state)
        CCC_IDLE: begin
          if (req.rd && !req_done) begin
            if (hit && !req.swap) begin
              req_rdata <= dat_mem[hit_way][set_of(req.addr)][req.addr[3:2]]; // see RL19
              req_done  <= 1'b1;
            end else if (!req.swap && req.cacheable && ctrl[CCC_BIT_CACHE]
                         && ctrl[CCC_BIT_MMU]) begin
              state    <= CCC_FILL; // see RL3 see RL17 see RL20
              fill_cnt <= 2'h0;
              fill_way <= rnd;
            end else begin
              state <= CCC_SINGL; // see RL21 see RL22
            end
          end else if (req.wr && !req_done) begin
            state <= CCC_WRITE; // see RL23
          end
        end
        CCC_FILL: begin
          if (mem_ack) begin
            if (fill_cnt == req.addr[3:2]) begin
              req_rdata <= mem_rdata;
            end
            fill_cnt <= fill_cnt + 2'h1;
            if (fill_cnt == CCC_LAST_WORD) begin
              state    <= CCC_IDLE;
              req_done <= 1'b1;
            end
          end
        end
        CCC_SINGL: begin
          if (mem_ack) begin
            req_rdata <= mem_rdata;
            req_done  <= 1'b1;
            swap_wr   <= req.swap; // see RL22
            state     <= CCC_IDLE;
          end
        end
        CCC_WRITE: begin
          if (mem_ack) begin
            req_done <= 1'b1;
            swap_wr  <= 1'b0;
            state    <= CCC_IDLE;
          end
        end
        default: state <= CCC_IDLE;
      endcase
    end
  end

  // Line valid bits: flush wins over a fill finishing in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (reset || flush_all) begin
      for (int w = 0; w < CCC_WAYS; w++) begin
        vld[w] <= '0; // see RL14 see RL18
      end
    end else if (state == CCC_FILL && mem_ack && fill_cnt == CCC_LAST_WORD) begin
      vld[fill_way][set_of(req.addr)] <= 1'b1; // see RL20
    end else if (state == CCC_FILL && mem_ack && fill_cnt == 2'h0) begin
      vld[fill_way][set_of(req.addr)] <= 1'b0;
    end
  end

  // Tag and data arrays: line fills and write-hit updates.
  always_ff @(posedge sys_clk) begin
    if (state == CCC_FILL && mem_ack) begin
      dat_mem[fill_way][set_of(req.addr)][fill_cnt] <= mem_rdata; // see RL20
      tag_mem[fill_way][set_of(req.addr)]           <= tag_of(req.addr);
    end else if (state == CCC_WRITE && mem_ack && hit) begin
      dat_mem[hit_way][set_of(req.addr)][req.addr[3:2]] <= req.wdata; // see RL22 see RL23
    end
  end

  // External bus drive; fills walk the line from word 0.
  assign mem_req   = (state != CCC_IDLE);
  assign mem_wr    = (state == CCC_WRITE);
  assign mem_addr  = (state == CCC_FILL) ? {req.addr[31:4], fill_cnt, 2'h0} : req.addr;
  assign mem_wdata = req.wdata;
  assign mem_lock  = (req.swap && state == CCC_SINGL) || (swap_wr && req.wr); // see RL22

  // A trap answers every illegal transfer one cycle later.
  undef_trap_a: assert property (@(posedge sys_clk) disable iff (reset)
    cp.valid && (cp.user || cp.regno > CCC_REG_LASTOK) |=> cp_undef) // see RL1
    else $error("illegal transfer not trapped");
  // High registers never reach the control register.
  high_reg_a: assert property (@(posedge sys_clk) disable iff (reset)
    cp.valid && cp.regno > CCC_REG_LASTOK |=> $stable(ctrl)) // see RL15
    else $error("high register changed control");
  // Cache flush clears every valid bit.
  flush_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    flush_all |=> (vld[0] == '0 && vld[1] == '0 && vld[2] == '0 && vld[3] == '0)) // see RL14
    else $error("flush left a valid line");
  // No fill without cache and translation enabled.
  fill_gate_a: assert property (@(posedge sys_clk) disable iff (reset)
    state == CCC_FILL |-> ctrl[CCC_BIT_CACHE] && ctrl[CCC_BIT_MMU]) // see RL17
    else $error("fill while disabled");
  // A swap read never completes from the cache.
  swap_ext_a: assert property (@(posedge sys_clk) disable iff (reset)
    state == CCC_IDLE && req.rd && req.swap && !req_done |=> state == CCC_SINGL) // see RL22
    else $error("swap read hit cache");
  // Writes never start a fill.
  write_nofill_a: assert property (@(posedge sys_clk) disable iff (reset)
    state == CCC_WRITE |=> state != CCC_FILL) // see RL23
    else $error("write allocated a line");
  // Flush pulse follows a register 5 write.
  tlb_flush_a: assert property (@(posedge sys_clk) disable iff (reset)
    cp_ok && cp.write && cp.regno == CCC_REG_FSR |=> tlb_flush) // see RL11
    else $error("tlb flush missing");
  // Status bits 11:8 always read zero.
  fsr_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    cp_rdata[11:8] == 4'h0 || $past(cp.regno) != CCC_REG_FSR) // see RL10
    else $error("status high nibble set");

endmodule

/* test/ccc_mem_model.sv */
/*
  External memory stand-in that answers the cache block's word accesses.
  Assumes the block holds its mem_* request until mem_ack, one ack a word.
*/
`timescale 1ns/10ps
module ccc_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        mem_req,
  input  wire logic        mem_wr,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] salt,
  input  wire logic        slow,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  output logic [31:0]      n_rd,
  output logic [31:0]      n_wr
);
  logic [1:0]  wait_cnt;  // Wait cycles spent on the current word.
  logic [31:0] word;      // Value handed out with the last acknowledge.

  // Read data is only good with the ack; otherwise the inverse is shown so
  // that a block sampling too late cannot pass by luck.
  assign mem_rdata = mem_ack ? word : ~word;

  // Each word is answered after none or three wait cycles; data is the
  // address mixed with a salt so a cached copy differs from a fresh read.
  always_ff @(posedge sys_clk) begin
    mem_ack <= 1'b0;
    if (reset) begin
      wait_cnt <= 2'h0;
      n_rd     <= 32'h0;
      n_wr     <= 32'h0;
    end else if (mem_req && !mem_ack) begin
      if (!slow || wait_cnt == 2'h3) begin
        mem_ack  <= 1'b1;
        word     <= mem_addr ^ salt;
        wait_cnt <= 2'h0;
        n_rd     <= n_rd + {31'h0, !mem_wr};
        n_wr     <= n_wr + {31'h0, mem_wr};
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule

/* test/cache_config_control_test.sv */
/*
  Self-checking bench for the configuration bank and cache.
  Assumes the hand-over timing: coprocessor answers one cycle after the take.
*/
`timescale 1ns/10ps
module cache_config_control_test
  import ccc_pkg::*;
;
  typedef struct packed {
    logic        w;
    logic        u;
    logic [3:0]  r;
    logic [31:0] d;
    logic [2:0]  x;   // Expected {trap, flush, purge}.
    logic [31:0] rd;
    logic [7:0]  o;   // Expected configuration outputs.
  } ccc_row_s;

  localparam ccc_row_s ROWS [15] = '{
    '{1'b1, 1'b0, 4'h1, 32'h0000_0002, 3'h0, 32'h0, 8'h02},
    '{1'b0, 1'b0, 4'h1, 32'h0, 3'h0, 32'h0000_0002, 8'h02},
    '{1'b1, 1'b0, 4'h1, 32'h0000_0008, 3'h0, 32'h0, 8'h04},
    '{1'b1, 1'b0, 4'h1, 32'h0000_0030, 3'h0, 32'h0, 8'h18},
    '{1'b1, 1'b0, 4'h1, 32'h0000_0080, 3'h0, 32'h0, 8'h20},
    '{1'b1, 1'b0, 4'h1, 32'h0000_0300, 3'h0, 32'h0, 8'hc0},
    '{1'b0, 1'b0, 4'h1, 32'h0, 3'h0, 32'h0000_0300, 8'hc0},
    '{1'b1, 1'b1, 4'h1, 32'h0000_0001, 3'h4, 32'h0, 8'hc0},
    '{1'b0, 1'b1, 4'h1, 32'h0, 3'h4, 32'h0, 8'hc0},
    '{1'b1, 1'b0, 4'h2, 32'h1234_4000, 3'h0, 32'h0, 8'hc0},
    '{1'b1, 1'b0, 4'h3, 32'ha5a5_0f0f, 3'h0, 32'h0, 8'hc0},
    '{1'b1, 1'b0, 4'h4, 32'hffff_ffff, 3'h0, 32'h0, 8'hc0},
    '{1'b0, 1'b0, 4'h4, 32'h0, 3'h0, 32'h0, 8'hc0},
    '{1'b1, 1'b0, 4'h5, 32'hffff_ffff, 3'h2, 32'h0, 8'hc0},
    '{1'b1, 1'b0, 4'h6, 32'h0000_5000, 3'h1, 32'h0, 8'hc0}};

  logic        sys_clk, reset, data_fault, cp_undef, req_done, tlb_flush, tlb_purge;
  logic        mem_req, mem_wr, mem_lock, mem_ack, slow, fill_on;
  logic        mmu_on, align_check, wbuf_on, prog32, data32, big_endian, sys_bit, rom_bit;
  logic [7:0]  fault_info, cfg;
  logic [31:0] cp_rdata, req_rdata, mem_addr, mem_wdata, mem_rdata, table_base;
  logic [31:0] domain_access, tlb_purge_addr, salt, n_rd, n_wr, fill_addr, q, n, r0, w0;
  ccc_cp_s     cp;
  ccc_req_s    req;
  int          bad_count, n_checks, cycles;

  assign cfg = {rom_bit, sys_bit, big_endian, data32, prog32, wbuf_on, align_check, mmu_on};

  ccc_cache_config_control dut (.sys_clk(sys_clk), .reset(reset), .cp(cp),
    .cp_undef(cp_undef), .cp_rdata(cp_rdata), .req(req), .data_fault(data_fault),
    .fault_info(fault_info), .req_done(req_done), .req_rdata(req_rdata),
    .mem_req(mem_req), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_lock(mem_lock), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mmu_on(mmu_on),
    .align_check(align_check), .wbuf_on(wbuf_on), .prog32(prog32), .data32(data32),
    .big_endian(big_endian), .sys_bit(sys_bit), .rom_bit(rom_bit),
    .table_base(table_base), .domain_access(domain_access), .tlb_flush(tlb_flush),
    .tlb_purge(tlb_purge), .tlb_purge_addr(tlb_purge_addr));

  ccc_mem_model mem (.sys_clk(sys_clk), .reset(reset), .mem_req(mem_req),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .salt(salt), .slow(slow),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .n_rd(n_rd), .n_wr(n_wr));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One coprocessor transfer, then its one-cycle answers are looked at.
  task automatic cp_op(input ccc_row_s r);
    @(posedge sys_clk);
    #1;
    cp = '{1'b1, r.w, r.u, r.r, r.d};
    @(posedge sys_clk);
    #1;
    cp.valid = 1'b0;
    chk({29'h0, cp_undef, tlb_flush, tlb_purge}, {29'h0, r.x});
    if (!r.w && !r.x[2]) chk(cp_rdata & (r.r == 4'h5 ? 32'hfff : 32'hffff_ffff), r.rd);
    chk({24'h0, cfg}, {24'h0, r.o});
  endtask

  // One core request, k = {rd, wr, swap, cacheable}; a swap read keeps the
  // request up so the write phase is presented without the usual leading clock wait.
  task automatic acc(input logic [3:0] k, input logic [31:0] a, d);
    if (!req.swap) begin
      @(posedge sys_clk);
      #1;
    end
    req = '{k[3], k[2], k[1], k[0], a, d};
    n = 32'h0;
    do begin
      @(posedge sys_clk);
      #1;
      n = n + 32'h1;
    end while (req_done !== 1'b1 && n < 32'h3c);
    chk({31'h0, req_done}, 32'h1);
    q = req_rdata;
    if (!(k[3] && k[1])) req = '0;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Watches line-fill addresses, the lock flag and the run time.
  always @(posedge sys_clk) begin
    cycles++;
    if (mem_ack && fill_on) begin
      chk(mem_addr, fill_addr);
      fill_addr = fill_addr + 32'h4;
    end
    if (mem_req && req.swap) chk({31'h0, mem_lock}, 32'h1);
    // A write goes out at the core's own address with the core's data.
    if (mem_req && mem_wr) begin
      chk(mem_addr, req.addr);
      chk(mem_wdata, req.wdata);
    end
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  initial begin
    {reset, slow, fill_on} = 3'b100;
    cp = '0;
    req = '0;
    data_fault = 1'b0;
    fault_info = 8'h0;
    salt = 32'h5a5a_0000;
    repeat (16) @(posedge sys_clk);
    #1 reset = 1'b0;
    for (int i = 0; i < 15; i++) cp_op(ROWS[i]);
    chk(table_base, 32'h1234_4000);
    chk(domain_access, 32'ha5a5_0f0f);
    chk(tlb_purge_addr, 32'h0000_5000);
    for (int i = 8; i < 16; i++) begin
      cp_op('{1'b1, 1'b0, 4'(i), 32'h0, 3'h4, 32'h0, 8'hc0});
      cp_op('{1'b0, 1'b0, 4'(i), 32'h0, 3'h4, 32'h0, 8'hc0});
    end
    // A data fault seen during an address phase is kept for software.
    @(posedge sys_clk);
    #1;
    {req.addr, data_fault, fault_info} = {32'h0000_4444, 1'b1, 8'ha7};
    @(posedge sys_clk);
    #1 data_fault = 1'b0;
    cp_op('{1'b0, 1'b0, 4'h5, 32'h0, 3'h0, 32'h0000_00a7, 8'hc0});
    cp_op('{1'b0, 1'b0, 4'h6, 32'h0, 3'h0, 32'h0000_4444, 8'hc0});
    cp_op('{1'b1, 1'b0, 4'h1, 32'h0000_0005, 3'h0, 32'h0, 8'h01});
    {slow, fill_on, fill_addr, r0} = {2'b11, 32'h0000_1230, n_rd};
    acc(4'h9, 32'h0000_1238, 32'h0);
    {slow, fill_on, salt} = {2'b00, 32'h3c3c_0000};
    chk(n_rd - r0, 32'h4);
    chk(q, 32'h5a5a_1238);
    acc(4'h9, 32'h0000_1234, 32'h0);
    chk(n, 32'h1);
    cp_op('{1'b1, 1'b0, 4'h1, 32'h0000_0001, 3'h0, 32'h0, 8'h01});
    acc(4'h8, 32'h0000_123c, 32'h0);
    chk(q, 32'h5a5a_123c);
    chk(n_rd - r0, 32'h4);
    cp_op('{1'b1, 1'b0, 4'h1, 32'h0000_0005, 3'h0, 32'h0, 8'h01});
    r0 = n_rd;
    acc(4'h8, 32'h0000_2000, 32'h0);
    acc(4'h8, 32'h0000_2000, 32'h0);
    chk(n_rd - r0, 32'h2);
    {r0, w0} = {n_rd, n_wr};
    acc(4'h5, 32'h0000_3000, 32'h1111_2222);
    acc(4'h9, 32'h0000_3000, 32'h0);
    acc(4'h5, 32'h0000_1234, 32'hdead_beef);
    acc(4'h9, 32'h0000_1234, 32'h0);
    chk(q, 32'hdead_beef);
    chk(n_wr - w0, 32'h2);
    chk(n_rd - r0, 32'h4);
    r0 = n_rd;
    acc(4'hb, 32'h0000_1234, 32'h0);
    chk(q, 32'h3c3c_1234);
    acc(4'h7, 32'h0000_1234, 32'h0bad_cafe);
    acc(4'h9, 32'h0000_1234, 32'h0);
    chk(q, 32'h0bad_cafe);
    chk(n_rd - r0, 32'h1);
    cp_op('{1'b1, 1'b0, 4'h7, 32'hffff_ffff, 3'h0, 32'h0, 8'h01});
    r0 = n_rd;
    acc(4'h9, 32'h0000_1234, 32'h0);
    chk(q, 32'h3c3c_1234);
    chk(n_rd - r0, 32'h4);
    // A second reset in mid-run must drop the enables and the lines.
    @(posedge sys_clk);
    #1 reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 {reset, salt} = {1'b0, 32'h0f0f_0000};
    chk({24'h0, cfg}, 32'h0);
    cp_op('{1'b0, 1'b0, 4'h1, 32'h0, 3'h0, 32'h0, 8'h00});
    acc(4'h9, 32'h0000_1234, 32'h0);
    chk(q, 32'h0f0f_1234);
    tally_and_finish;
  end
endmodule
